//--- hdl/shp_pkg.sv
// package: constants and types for the standby and protect controller
package shp_pkg;
    // protection key value that unlocks the protected registers
    localparam logic [7:0] PROTECT_UNLOCK_KEY = 8'h1f;
    // halt mode field encodings
    localparam logic [1:0] HALT_SEL_NONE      = 2'h0;
    localparam logic [1:0] HALT_SEL_STOP      = 2'h1;
    localparam logic [1:0] HALT_SEL_OSC_IDLE  = 2'h2;
    localparam logic [1:0] HALT_SEL_CPU_IDLE  = 2'h3;
    // non-maskable interrupt level
    localparam logic [2:0] NMI_LEVEL          = 3'h7;
    // entry window in gear clock cycles for osc idle and stop
    localparam int         ENTRY_GEAR_CYCLES  = 5;
    // protected register select codes
    localparam logic [2:0] PREG_CS_WAIT       = 3'h0;
    localparam logic [2:0] PREG_SYS_CLK0      = 3'h1;
    localparam logic [2:0] PREG_SYS_CLK1      = 3'h2;
    localparam logic [2:0] PREG_SYS_CLK2      = 3'h3;
    localparam logic [2:0] PREG_NOISE_CTRL    = 3'h4;
    localparam logic [2:0] PREG_PLL_CTRL      = 3'h5;
    localparam logic [2:0] PREG_PROTECT_KEY   = 3'h6;
    localparam logic [2:0] PREG_OTHER         = 3'h7;
    // reset values
    localparam logic       PROTECT_RST        = 1'b0;
    localparam logic [1:0] HALT_SEL_RST       = 2'h3;

    typedef enum logic [2:0] {
        SHP_RUN,
        SHP_ENTER,
        SHP_CPU_IDLE,
        SHP_OSC_IDLE,
        SHP_STOP,
        SHP_WARMUP
    } shp_state_e;
endpackage : shp_pkg

//--- hdl/shp_wake_eval.sv
// module: evaluates interrupt requests against mask and halt mode
`timescale 1ns/1ps
module shp_wake_eval #(
    parameter int NUM_SRC = 8
) (
    input  wire logic [NUM_SRC-1:0]   req_i,
    input  wire logic [NUM_SRC*3-1:0] level_i,
    input  wire logic [NUM_SRC-1:0]   nmi_src_i,
    input  wire logic [NUM_SRC-1:0]   forced_src_i,
    input  wire logic [NUM_SRC-1:0]   allow_src_i,
    input  wire logic [2:0]           mask_level_i,
    output logic                      wake_service_o,
    output logic                      wake_resume_o,
    output logic                      wake_warmup_o,
    input  wire logic [NUM_SRC-1:0]   warm_src_i
);
    logic [NUM_SRC-1:0] svc;
    logic [NUM_SRC-1:0] res;

    initial begin
        if (NUM_SRC < 1) $error("shp_wake_eval: NUM_SRC must be positive");
    end

    // per source: enabled level, nmi, or masked forced source
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
        logic [2:0] lvl;
        assign lvl    = nmi_src_i[g] ? shp_pkg::NMI_LEVEL : level_i[g*3 +: 3];
        assign svc[g] = req_i[g] && allow_src_i[g] &&
                        (nmi_src_i[g] || lvl >= mask_level_i);
        assign res[g] = req_i[g] && allow_src_i[g] && !svc[g] && forced_src_i[g];
    end

    assign wake_service_o = |svc;
    assign wake_resume_o  = |res;
    // warm-up needed when a release source of that class fires
    assign wake_warmup_o  = |((svc | res) & warm_src_i);
endmodule : shp_wake_eval

//--- hdl/shp_standby_ctrl.sv
// module: halt mode sequencer and special register write protect
//
// Operation
// - non-key write to key register enables protection
// - unlock key write disables protection
// - protect state readable in noise control register
// - reset clears protection
// - protected set listed; key register always writable
// - halt instruction enters mode from halt_mode_sel
// - cpu idle: peripherals run per idle-run bits
// - osc idle: only oscillator and clock timer
// - stop: everything including oscillator halts
// - idle modes hold port outputs
// - level at or above mask releases, serviced
// - below mask no release, except nmi and forced sources
// - masked ext0-4 and clock timer resume, flag kept
// - nmi level fixed at seven
// - entry-window interrupt held pending, serviced later
// - stop release by nmi/ext0-4 waits warm-up
// - reset releases halt, ram kept
// - interrupt release keeps all settings
// - osc idle restart synchronous to clock
// - stop release picks clock by select bit
`timescale 1ns/1ps
module shp_standby_ctrl #(
    parameter int NUM_SRC = 8,
    parameter int NUM_PER = 11
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // cpu special register write port
    input  wire logic                 sfr_wr_i,
    input  wire logic [2:0]           sfr_sel_i,
    input  wire logic [7:0]           sfr_wdata_i,
    output logic                      sfr_wr_allow_o,
    output logic                      protect_on_o,
    // halt control
    input  wire logic                 halt_exec_i,
    input  wire logic [1:0]           halt_mode_sel_i,
    input  wire logic                 gear_clock_tick_i,
    input  wire logic                 warmup_done_i,
    input  wire logic                 release_clk_sel_i,
    // interrupt controller
    input  wire logic [NUM_SRC-1:0]   irq_req_i,
    input  wire logic [NUM_SRC*3-1:0] irq_level_i,
    input  wire logic [2:0]           irq_mask_level_i,
    input  wire logic [NUM_SRC-1:0]   nmi_src_i,
    input  wire logic [NUM_SRC-1:0]   forced_src_i,
    input  wire logic [NUM_SRC-1:0]   cpu_idle_src_i,
    input  wire logic [NUM_SRC-1:0]   osc_idle_src_i,
    input  wire logic [NUM_SRC-1:0]   stop_src_i,
    input  wire logic [NUM_SRC-1:0]   stop_warm_src_i,
    input  wire logic [NUM_PER-1:0]   per_idle_run_i,
    // outputs to cpu, clocks and peripherals
    output logic                      cpu_halted_o,
    output logic                      cpu_idle_o,
    output logic                      osc_idle_o,
    output logic                      stop_o,
    output logic                      osc_run_o,
    output logic                      clock_timer_run_o,
    output logic [NUM_PER-1:0]        per_run_o,
    output logic                      port_hold_o,
    output logic                      warmup_start_o,
    output logic                      resume_service_o,
    output logic                      resume_next_o,
    output logic                      pending_hold_o,
    output logic                      sel_low_clk_o
);
    typedef struct packed {
        logic                   protect;
        shp_pkg::shp_state_e    state;
        logic [2:0]             gear_cnt;
        logic                   pending;
        logic                   svc_ff;
        logic                   next_ff;
        logic                   warm_svc;
        logic                   warm_start;
        logic                   low_clk;
    } shp_state_s;

    shp_state_s st_ff;
    shp_state_s nxt_st;
    logic       wk_svc;
    logic       wk_res;
    logic       wk_warm;
    logic [NUM_SRC-1:0] allow;

    initial begin
        if (NUM_SRC < 1 || NUM_PER < 1) $error("shp_standby_ctrl: bad sizes");
    end

    // sources allowed to release differ per halt mode
    always_comb begin
        case (st_ff.state)
            shp_pkg::SHP_CPU_IDLE: allow = cpu_idle_src_i;
            shp_pkg::SHP_OSC_IDLE: allow = osc_idle_src_i;
            shp_pkg::SHP_STOP:     allow = stop_src_i;
            default:               allow = '0;
        endcase
    end

    shp_wake_eval #(
        .NUM_SRC (NUM_SRC)
    ) u_wake (
        .req_i          (irq_req_i),
        .level_i        (irq_level_i),
        .nmi_src_i      (nmi_src_i),
        .forced_src_i   (forced_src_i),
        .allow_src_i    (allow),
        .mask_level_i   (irq_mask_level_i),
        .wake_service_o (wk_svc),
        .wake_resume_o  (wk_res),
        .wake_warmup_o  (wk_warm),
        .warm_src_i     (stop_warm_src_i)
    );

    // next state: protection register and halt sequencer
    always_comb begin
        nxt_st            = st_ff;
        nxt_st.svc_ff     = 1'b0;
        nxt_st.next_ff    = 1'b0;
        nxt_st.warm_start = 1'b0;
        // key register is never blocked
        if (sfr_wr_i && sfr_sel_i == shp_pkg::PREG_PROTECT_KEY) begin
            nxt_st.protect = (sfr_wdata_i != shp_pkg::PROTECT_UNLOCK_KEY);
        end
        case (st_ff.state)
            shp_pkg::SHP_RUN: begin
                if (halt_exec_i) begin
                    nxt_st.gear_cnt = '0;
                    nxt_st.pending  = 1'b0;
                    case (halt_mode_sel_i)
                        shp_pkg::HALT_SEL_CPU_IDLE: nxt_st.state = shp_pkg::SHP_CPU_IDLE;
                        shp_pkg::HALT_SEL_OSC_IDLE,
                        shp_pkg::HALT_SEL_STOP: begin
                            nxt_st.state    = shp_pkg::SHP_ENTER;
                            nxt_st.low_clk  = halt_mode_sel_i[0];
                        end
                        default: nxt_st.state = shp_pkg::SHP_RUN;
                    endcase
                end
            end
            shp_pkg::SHP_ENTER: begin
                // requests now cannot release; remember them
                if (|irq_req_i) nxt_st.pending = 1'b1;
                if (gear_clock_tick_i) begin
                    if (st_ff.gear_cnt ==
                        3'(shp_pkg::ENTRY_GEAR_CYCLES - 1)) begin
                        nxt_st.state = st_ff.low_clk ? shp_pkg::SHP_STOP
                                                     : shp_pkg::SHP_OSC_IDLE;
                    end else begin
                        nxt_st.gear_cnt = st_ff.gear_cnt + 3'h1;
                    end
                end
            end
            shp_pkg::SHP_CPU_IDLE,
            shp_pkg::SHP_OSC_IDLE: begin
                // release registered on the clock edge
                if (wk_svc || wk_res) begin
                    nxt_st.state   = shp_pkg::SHP_RUN;
                    nxt_st.svc_ff  = wk_svc;
                    nxt_st.next_ff = !wk_svc;
                    nxt_st.pending = 1'b0;
                end
            end
            shp_pkg::SHP_STOP: begin
                if (wk_svc || wk_res) begin
                    nxt_st.warm_svc = wk_svc;
                    if (wk_warm) begin
                        nxt_st.state      = shp_pkg::SHP_WARMUP;
                        nxt_st.warm_start = 1'b1;
                    end else begin
                        nxt_st.state   = shp_pkg::SHP_RUN;
                        nxt_st.svc_ff  = wk_svc;
                        nxt_st.next_ff = !wk_svc;
                        nxt_st.pending = 1'b0;
                    end
                end
            end
            shp_pkg::SHP_WARMUP: begin
                if (warmup_done_i) begin
                    nxt_st.state   = shp_pkg::SHP_RUN;
                    nxt_st.svc_ff  = st_ff.warm_svc;
                    nxt_st.next_ff = !st_ff.warm_svc;
                    nxt_st.pending = 1'b0;
                end
            end
            default: nxt_st.state = shp_pkg::SHP_RUN;
        endcase
    end

    // reset ends any halt and clears protection; ram lives elsewhere
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff.protect    <= shp_pkg::PROTECT_RST;
            st_ff.state      <= shp_pkg::SHP_RUN;
            st_ff.gear_cnt   <= 3'h0;
            st_ff.pending    <= 1'b0;
            st_ff.svc_ff     <= 1'b0;
            st_ff.next_ff    <= 1'b0;
            st_ff.warm_svc   <= 1'b0;
            st_ff.warm_start <= 1'b0;
            st_ff.low_clk    <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // write gating for the protected set
    assign sfr_wr_allow_o = sfr_wr_i &&
        (!st_ff.protect || sfr_sel_i == shp_pkg::PREG_PROTECT_KEY ||
         sfr_sel_i == shp_pkg::PREG_OTHER);
    assign protect_on_o = st_ff.protect;

    // mode decode
    assign cpu_idle_o = (st_ff.state == shp_pkg::SHP_CPU_IDLE);
    assign osc_idle_o = (st_ff.state == shp_pkg::SHP_OSC_IDLE);
    assign stop_o     = (st_ff.state == shp_pkg::SHP_STOP) ||
                        (st_ff.state == shp_pkg::SHP_WARMUP);
    assign cpu_halted_o = (st_ff.state != shp_pkg::SHP_RUN);

    // oscillator off only in stop; warm-up runs it again
    assign osc_run_o         = (st_ff.state != shp_pkg::SHP_STOP);
    assign clock_timer_run_o = !stop_o;
    // peripherals: all in run, enabled ones in cpu idle, none otherwise
    for (genvar p = 0; p < NUM_PER; p++) begin : g_per
        assign per_run_o[p] = (st_ff.state == shp_pkg::SHP_RUN) ||
                              (cpu_idle_o && per_idle_run_i[p]);
    end
    assign port_hold_o = cpu_idle_o || osc_idle_o;

    // release pulses; settings untouched by interrupt release
    assign resume_service_o = st_ff.svc_ff;
    assign resume_next_o    = st_ff.next_ff;
    assign pending_hold_o   = st_ff.pending;
    assign warmup_start_o   = st_ff.warm_start;
    assign sel_low_clk_o    = release_clk_sel_i;
endmodule : shp_standby_ctrl

//--- test/shp_irq_model.sv
// interrupt controller stand-in driving request lines and levels
`timescale 1ns/1ps
module shp_irq_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        fire_i,
    input  wire logic [2:0]  src_i,
    input  wire logic [2:0]  lvl_i,
    input  wire logic        drop_i,
    input  wire logic        done_i,
    output logic      [7:0]  irq_req_o,
    output logic      [23:0] irq_level_o
);
    // lines stay up until the cpu resumes or drop_i clears them; dropping early would lose a level wake
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_req_o   <= 8'h00;
            irq_level_o <= 24'h000000;
        end else if (drop_i || done_i) begin
            irq_req_o <= 8'h00;
        end else if (fire_i) begin
            irq_req_o[src_i]          <= 1'b1;
            irq_level_o[src_i*3 +: 3] <= lvl_i;
        end
    end
endmodule : shp_irq_model

//--- test/shp_standby_ctrl_assertions.sv
// checker: port assertions for the standby and protect controller
`timescale 1ns/1ps
module shp_standby_chk #(
    parameter int NUM_SRC = 8,
    parameter int NUM_PER = 11
) (
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               sfr_wr_i,
    input wire logic [2:0]         sfr_sel_i,
    input wire logic [7:0]         sfr_wdata_i,
    input wire logic               sfr_wr_allow_o,
    input wire logic               protect_on_o,
    input wire logic               halt_exec_i,
    input wire logic [1:0]         halt_mode_sel_i,
    input wire logic               warmup_done_i,
    input wire logic [NUM_SRC-1:0] irq_req_i,
    input wire logic [NUM_SRC-1:0] nmi_src_i,
    input wire logic [NUM_SRC-1:0] stop_warm_src_i,
    input wire logic [NUM_PER-1:0] per_idle_run_i,
    input wire logic               cpu_halted_o,
    input wire logic               cpu_idle_o,
    input wire logic               osc_idle_o,
    input wire logic               stop_o,
    input wire logic               osc_run_o,
    input wire logic               clock_timer_run_o,
    input wire logic [NUM_PER-1:0] per_run_o,
    input wire logic               port_hold_o,
    input wire logic               warmup_start_o,
    input wire logic               resume_service_o,
    input wire logic               resume_next_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // building blocks: key write, halt taken in run, nmi while idle
    sequence s_key_wr;
        sfr_wr_i && sfr_sel_i == shp_pkg::PREG_PROTECT_KEY;
    endsequence
    sequence s_halt_run;
        halt_exec_i && !cpu_halted_o;
    endsequence
    sequence s_nmi_idle;
        (cpu_idle_o || osc_idle_o) && (irq_req_i & nmi_src_i) != '0;
    endsequence
    a_key_lock: assert property (s_key_wr ##0 sfr_wdata_i != shp_pkg::PROTECT_UNLOCK_KEY
        |=> protect_on_o) else $error("key write did not lock");
    a_key_unlock: assert property (s_key_wr ##0 sfr_wdata_i == shp_pkg::PROTECT_UNLOCK_KEY
        |=> !protect_on_o) else $error("unlock code did not unlock");
    a_write_gate: assert property (sfr_wr_allow_o == (sfr_wr_i && (!protect_on_o
        || sfr_sel_i >= shp_pkg::PREG_PROTECT_KEY))) else $error("write gate wrong");
    a_rst_clear: assert property ($fell(rst_i) |-> !protect_on_o && !cpu_halted_o)
        else $error("reset left protect or halt");
    a_cpu_enter: assert property (s_halt_run ##0 halt_mode_sel_i == 2'h3 |=> cpu_idle_o)
        else $error("cpu idle not entered");
    a_halt_none: assert property (s_halt_run ##0 halt_mode_sel_i == 2'h0 |=> !cpu_halted_o)
        else $error("mode 00 halted the cpu");
    a_cpu_idle_run: assert property (cpu_idle_o |-> per_run_o == per_idle_run_i && port_hold_o)
        else $error("cpu idle run enables wrong");
    a_osc_only: assert property (osc_idle_o |-> osc_run_o && clock_timer_run_o
        && per_run_o == '0 && port_hold_o) else $error("osc idle outputs wrong");
    a_stop_all: assert property ($rose(stop_o) |-> !osc_run_o && !clock_timer_run_o
        && per_run_o == '0) else $error("stop left something running");
    a_nmi_wake: assert property (s_nmi_idle |-> ##[1:2] resume_service_o)
        else $error("nmi did not wake");
    a_warm_start: assert property (stop_o && !osc_run_o && (irq_req_i & stop_warm_src_i) != '0
        |=> warmup_start_o) else $error("no warm-up start");
    a_warm_wait: assert property (warmup_start_o && !warmup_done_i
        |=> !resume_service_o && !resume_next_o) else $error("resumed before warm-up");
endmodule : shp_standby_chk
bind shp_standby_ctrl shp_standby_chk #(.NUM_SRC(NUM_SRC), .NUM_PER(NUM_PER)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .sfr_wr_i(sfr_wr_i), .sfr_sel_i(sfr_sel_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_wr_allow_o(sfr_wr_allow_o), .protect_on_o(protect_on_o),
    .halt_exec_i(halt_exec_i), .halt_mode_sel_i(halt_mode_sel_i),
    .warmup_done_i(warmup_done_i), .irq_req_i(irq_req_i), .nmi_src_i(nmi_src_i),
    .stop_warm_src_i(stop_warm_src_i), .per_idle_run_i(per_idle_run_i),
    .cpu_halted_o(cpu_halted_o), .cpu_idle_o(cpu_idle_o), .osc_idle_o(osc_idle_o),
    .stop_o(stop_o), .osc_run_o(osc_run_o), .clock_timer_run_o(clock_timer_run_o),
    .per_run_o(per_run_o), .port_hold_o(port_hold_o), .warmup_start_o(warmup_start_o),
    .resume_service_o(resume_service_o), .resume_next_o(resume_next_o)
);

//--- test/tb.sv
// testbench: standby modes, wake sources and register protection
`timescale 1ns/1ps
module tb;
    logic        clk_i = 1'b0, rst_i = 1'b1, sfr_wr_i = 1'b0, halt_exec_i = 1'b0;
    logic        gear_clock_tick_i = 1'b0, warmup_done_i = 1'b0, release_clk_sel_i = 1'b0;
    logic        fire = 1'b0, drop = 1'b0, prot_exp = 1'b0;
    logic [2:0]  sfr_sel_i = 3'h0, irq_mask_level_i = 3'h0, src = 3'h0, lvl = 3'h0;
    logic [7:0]  sfr_wdata_i = 8'h00, nmi_src_i = 8'h01, forced_src_i = 8'h06;
    logic [7:0]  cpu_idle_src_i = 8'h1f, osc_idle_src_i = 8'h07;
    logic [7:0]  stop_src_i = 8'h03, stop_warm_src_i = 8'h03, irq_req_i;
    logic [1:0]  halt_mode_sel_i = 2'h0;
    logic [10:0] per_idle_run_i = 11'h000, per_run_o;
    logic [23:0] irq_level_i;
    logic        sfr_wr_allow_o, protect_on_o, cpu_halted_o, cpu_idle_o, osc_idle_o, stop_o;
    logic        osc_run_o, clock_timer_run_o, port_hold_o, warmup_start_o;
    logic        resume_service_o, resume_next_o, pending_hold_o, sel_low_clk_o;
    int          miscompares = 0, n_checks = 0, cycles = 0;
    shp_standby_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .sfr_wr_i(sfr_wr_i),
        .sfr_sel_i(sfr_sel_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wr_allow_o(sfr_wr_allow_o),
        .protect_on_o(protect_on_o), .halt_exec_i(halt_exec_i), .halt_mode_sel_i(halt_mode_sel_i),
        .gear_clock_tick_i(gear_clock_tick_i), .warmup_done_i(warmup_done_i),
        .release_clk_sel_i(release_clk_sel_i), .irq_req_i(irq_req_i), .irq_level_i(irq_level_i),
        .irq_mask_level_i(irq_mask_level_i), .nmi_src_i(nmi_src_i), .forced_src_i(forced_src_i),
        .cpu_idle_src_i(cpu_idle_src_i), .osc_idle_src_i(osc_idle_src_i),
        .stop_src_i(stop_src_i), .stop_warm_src_i(stop_warm_src_i),
        .per_idle_run_i(per_idle_run_i), .cpu_halted_o(cpu_halted_o), .cpu_idle_o(cpu_idle_o),
        .osc_idle_o(osc_idle_o), .stop_o(stop_o), .osc_run_o(osc_run_o),
        .clock_timer_run_o(clock_timer_run_o), .per_run_o(per_run_o), .port_hold_o(port_hold_o),
        .warmup_start_o(warmup_start_o), .resume_service_o(resume_service_o),
        .resume_next_o(resume_next_o), .pending_hold_o(pending_hold_o),
        .sel_low_clk_o(sel_low_clk_o));
    shp_irq_model u_irq (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .src_i(src), .lvl_i(lvl),
        .drop_i(drop), .done_i(resume_service_o | resume_next_o), .irq_req_o(irq_req_i),
        .irq_level_o(irq_level_i));
    // 4 ns clock, gear tick every other cycle so entry spans ten cycles
    initial forever #2 clk_i = ~clk_i;
    always @(negedge clk_i) gear_clock_tick_i <= ~gear_clock_tick_i;
    // hang guard, far above the fewer than 150 cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report;
        end
    end
    task chk(input string nm, input logic [15:0] s, e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task final_report;
        if (miscompares == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report
    function logic sig(int k);
        case (k)
            0: return resume_service_o;
            1: return resume_next_o;
            2: return osc_idle_o;
            3: return stop_o;
            default: return warmup_start_o;
        endcase
    endfunction : sig
    // bounded wait on a completion output, then judge it
    task wt(input string nm, input int k, n);
        for (int i = 0; i < n && sig(k) !== 1'b1; i++) @(negedge clk_i);
        chk(nm, sig(k), 1'b1);
    endtask : wt
    // strobe stays high across back-to-back writes; caller lowers it
    task wr(input logic [2:0] s, input logic [7:0] d);
        sfr_sel_i = s;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        #1 chk("wr_allow", sfr_wr_allow_o, !prot_exp || s >= 3'h6);
        @(negedge clk_i);
        if (s == 3'h6) prot_exp = (d != shp_pkg::PROTECT_UNLOCK_KEY);
        chk("protect", protect_on_o, prot_exp);
    endtask : wr
    task halt(input logic [1:0] m);
        halt_mode_sel_i = m;
        halt_exec_i = 1'b1;
        @(negedge clk_i);
        halt_exec_i = 1'b0;
    endtask : halt
    task irq(input logic [2:0] s, l);
        src = s;
        lvl = l;
        fire = 1'b1;
        @(negedge clk_i);
        fire = 1'b0;
    endtask : irq
    // main sequence
    initial begin
        void'($urandom(32'hc93b));
        repeat (10) @(negedge clk_i);
        rst_i = 1'b0;
        chk("protect_rst", protect_on_o, 1'b0);
        for (int i = 0; i < 40; i++) wr(i[0] ? 3'h6 : 3'($urandom_range(0, 7)),
            (i % 3 == 1) ? shp_pkg::PROTECT_UNLOCK_KEY : 8'($urandom));
        sfr_wr_i = 1'b0;
        // cpu idle: below-mask source holds, masked forced source resumes
        irq_mask_level_i = 3'h4;
        per_idle_run_i = 11'($urandom) | 11'h030;
        halt(2'h3);
        chk("cpu_idle", {cpu_idle_o, port_hold_o, per_run_o}, {2'b11, per_idle_run_i});
        irq(3'h3, 3'($urandom_range(0, 3)));
        repeat (3) @(negedge clk_i);
        chk("no_wake", cpu_idle_o, 1'b1);
        irq(3'h1, 3'h0);
        wt("resume_next", 1, 4);
        chk("no_service", resume_service_o, 1'b0);
        @(negedge clk_i);
        chk("kept", {cpu_halted_o, protect_on_o}, {1'b0, prot_exp});
        halt(2'h3);
        irq(3'h4, 3'($urandom_range(4, 7)));
        wt("wake_service", 0, 4);
        // osc idle: request inside the entry window only goes pending
        halt(2'h2);
        irq(3'h1, 3'h5);
        @(negedge clk_i);
        chk("pending", pending_hold_o, 1'b1);
        drop = 1'b1;
        @(negedge clk_i);
        drop = 1'b0;
        wt("osc_idle", 2, 20);
        chk("osc_only", {osc_run_o, clock_timer_run_o, port_hold_o, per_run_o}, 14'h3800);
        irq(3'h0, 3'h0);
        wt("nmi_wake", 0, 4);
        // stop: masked ext0 wakes only after warm-up ends
        release_clk_sel_i = 1'($urandom);
        halt(2'h1);
        wt("stop", 3, 20);
        chk("stop_all", {osc_run_o, clock_timer_run_o, per_run_o}, 13'h0000);
        irq(3'h1, 3'h0);
        wt("warm_start", 4, 4);
        repeat (3) @(negedge clk_i);
        chk("warm_wait", {stop_o, resume_next_o}, 2'b10);
        warmup_done_i = 1'b1;
        @(negedge clk_i);
        warmup_done_i = 1'b0;
        chk("stop_wake", resume_next_o, 1'b1);
        chk("clk_sel", sel_low_clk_o, release_clk_sel_i);
        halt(2'h0);
        chk("no_mode", cpu_halted_o, 1'b0);
        // reset in mid-halt with protection on
        wr(3'h6, 8'h00);
        sfr_wr_i = 1'b0;
        halt(2'h3);
        rst_i = 1'b1;
        repeat (10) @(negedge clk_i);
        rst_i = 1'b0;
        chk("rst_release", {cpu_halted_o, protect_on_o}, 2'b00);
        final_report;
    end
endmodule : tb
